//--- rtl/phy_status_pkg.sv
package phy_status_pkg;

  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 16;
  localparam int          IRQ_W           = 6;

  // register indexes on the management port
  localparam logic [4:0]  STATUS_ADDR     = 5'h10;
  localparam logic [4:0]  FALSE_CAR_ADDR  = 5'h14;
  localparam logic [4:0]  RX_ERR_ADDR     = 5'h15;
  localparam logic [4:0]  XOVER_CTRL_ADDR = 5'h19;
  localparam logic [4:0]  TEN_BASE_ADDR   = 5'h1A;
  localparam logic [4:0]  IRQ_STAT_ADDR   = 5'h1C;
  localparam logic [4:0]  IRQ_MASK_ADDR   = 5'h1D;

  // status summary field positions
  localparam int          RSVD_BIT        = 15;
  localparam int          XOVER_BIT       = 14;
  localparam int          RX_ERR_BIT      = 13;
  localparam int          POLARITY_BIT    = 12;
  localparam int          FALSE_CAR_BIT   = 11;
  localparam int          SIG_DET_BIT     = 10;
  localparam int          LOCK_BIT        = 9;

  // ten base status/control field position
  localparam int          TB_POLARITY_BIT = 4;

  // crossover control field positions
  localparam int          AUTO_XOVER_BIT  = 1;
  localparam int          FORCE_XOVER_BIT = 0;

  // interrupt field positions
  localparam int          IRQ_RX_ERR      = 0;
  localparam int          IRQ_FALSE_CAR   = 1;
  localparam int          IRQ_POLARITY    = 2;
  localparam int          IRQ_SIG_LOST    = 3;
  localparam int          IRQ_LOCK_LOST   = 4;
  localparam int          IRQ_XOVER_CHG   = 5;

  // reset values
  localparam logic [1:0]  XOVER_CTRL_RST  = 2'h2;
  localparam logic [5:0]  IRQ_MASK_RST    = 6'h00;
  localparam logic [15:0] DATA_ZERO       = 16'h0000;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic rx_error;
    logic false_carrier;
    logic polarity_inverted;
    logic signal_detect;
    logic descr_lock;
    logic algo_swapped;
  } phy_sources_t;

endpackage

//--- rtl/phy_status_upper_bits.sv
module phy_status_upper_bits (
  input  wire logic                         clock,
  input  wire logic                         nrst,
  input  wire phy_status_pkg::mgmt_req_t    req,
  output logic [phy_status_pkg::DATA_W-1:0] rdata,
  input  wire phy_status_pkg::phy_sources_t src,
  output logic                              irq
);
  import phy_status_pkg::*;

  logic                rd_status;
  logic                rd_rx_err;
  logic                rd_false_car;
  logic                rd_ten_base;
  logic                wr_ctrl;
  logic                wr_irq_stat;
  logic                wr_irq_mask;
  logic                xover_w;
  logic                auto_xover_q;
  logic                force_xover_q;
  logic                xover_prev_q;
  logic                rx_err_q;
  logic                false_car_q;
  logic                polarity_q;
  logic                sig_det_q;
  logic                lock_q;
  logic                sig_prev_q;
  logic                lock_prev_q;
  logic [IRQ_W-1:0]    irq_event;
  logic [IRQ_W-1:0]    irq_stat_q;
  logic [IRQ_W-1:0]    irq_mask_q;
  logic [DATA_W-1:0]   status_w;
  logic [DATA_W-1:0]   rdata_d;
  logic [DATA_W-1:0]   rdata_q;

  assign rd_status    = req.rd && (req.addr == STATUS_ADDR);
  assign rd_rx_err    = req.rd && (req.addr == RX_ERR_ADDR);
  assign rd_false_car = req.rd && (req.addr == FALSE_CAR_ADDR);
  assign rd_ten_base  = req.rd && (req.addr == TEN_BASE_ADDR);
  assign wr_ctrl      = req.wr && (req.addr == XOVER_CTRL_ADDR);
  assign wr_irq_stat  = req.wr && (req.addr == IRQ_STAT_ADDR);
  assign wr_irq_mask  = req.wr && (req.addr == IRQ_MASK_ADDR);

  // crossover control settings
  always_ff @(posedge clock) begin
    if (!nrst) begin
      auto_xover_q  <= XOVER_CTRL_RST[AUTO_XOVER_BIT];
      force_xover_q <= XOVER_CTRL_RST[FORCE_XOVER_BIT];
    end else if (wr_ctrl) begin
      auto_xover_q  <= req.wdata[AUTO_XOVER_BIT];
      force_xover_q <= req.wdata[FORCE_XOVER_BIT];
    end
  end

  // forced wins, auto tracks the algorithm live, otherwise normal pairs
  always_comb begin
    if (force_xover_q) begin
      xover_w = 1'b1;
    end else if (auto_xover_q) begin
      xover_w = src.algo_swapped;
    end else begin
      xover_w = 1'b0;
    end
  end

  // receive error latch, a new event beats the clearing read
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rx_err_q <= 1'b0;
    end else if (src.rx_error) begin
      rx_err_q <= 1'b1;
    end else if (rd_rx_err) begin
      rx_err_q <= 1'b0;
    end
  end

  // false carrier latch
  always_ff @(posedge clock) begin
    if (!nrst) begin
      false_car_q <= 1'b0;
    end else if (src.false_carrier) begin
      false_car_q <= 1'b1;
    end else if (rd_false_car) begin
      false_car_q <= 1'b0;
    end
  end

  // polarity latch shared with the ten base register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      polarity_q <= 1'b0;
    end else if (src.polarity_inverted) begin
      polarity_q <= 1'b1;
    end else if (rd_ten_base) begin
      polarity_q <= 1'b0;
    end
  end

  // latch-low bits, refreshed by a status summary read
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sig_det_q <= 1'b0;
      lock_q    <= 1'b0;
    end else if (rd_status) begin
      sig_det_q <= src.signal_detect;
      lock_q    <= src.descr_lock;
    end else begin
      sig_det_q <= sig_det_q & src.signal_detect;
      lock_q    <= lock_q & src.descr_lock;
    end
  end

  // previous levels for change detection
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sig_prev_q   <= 1'b0;
      lock_prev_q  <= 1'b0;
      xover_prev_q <= 1'b0;
    end else begin
      sig_prev_q   <= src.signal_detect;
      lock_prev_q  <= src.descr_lock;
      xover_prev_q <= xover_w;
    end
  end

  always_comb begin
    irq_event                = '0;
    irq_event[IRQ_RX_ERR]    = src.rx_error;
    irq_event[IRQ_FALSE_CAR] = src.false_carrier;
    irq_event[IRQ_POLARITY]  = src.polarity_inverted && !polarity_q;
    irq_event[IRQ_SIG_LOST]  = sig_prev_q && !src.signal_detect;
    irq_event[IRQ_LOCK_LOST] = lock_prev_q && !src.descr_lock;
    irq_event[IRQ_XOVER_CHG] = xover_prev_q != xover_w;
  end

  // sticky interrupt bits, write one to clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clock) begin
        if (!nrst) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (wr_irq_stat && req.wdata[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_q <= req.wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // status summary view; writes to it are dropped, lower bits not held here
  always_comb begin
    status_w                = DATA_ZERO;
    status_w[RSVD_BIT]      = 1'b0;
    status_w[XOVER_BIT]     = xover_w;
    status_w[RX_ERR_BIT]    = rx_err_q;
    status_w[POLARITY_BIT]  = polarity_q;
    status_w[FALSE_CAR_BIT] = false_car_q;
    status_w[SIG_DET_BIT]   = sig_det_q;
    status_w[LOCK_BIT]      = lock_q;
  end

  always_comb begin
    rdata_d = DATA_ZERO;
    if (req.rd) begin
      case (req.addr)
        STATUS_ADDR: begin
          rdata_d = status_w;
        end
        TEN_BASE_ADDR: begin
          rdata_d[TB_POLARITY_BIT] = polarity_q;
        end
        XOVER_CTRL_ADDR: begin
          rdata_d[AUTO_XOVER_BIT]  = auto_xover_q;
          rdata_d[FORCE_XOVER_BIT] = force_xover_q;
        end
        IRQ_STAT_ADDR: begin
          rdata_d[IRQ_W-1:0] = irq_stat_q;
        end
        IRQ_MASK_ADDR: begin
          rdata_d[IRQ_W-1:0] = irq_mask_q;
        end
        default: begin
          rdata_d = DATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= DATA_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence status_read_s;
    rd_status;
  endsequence

  sequence sig_drop_s;
    src.signal_detect ##1 !src.signal_detect && !rd_status;
  endsequence

  top_bit_zero_a: assert property (
    status_read_s |=> (rdata[RSVD_BIT] == 1'b0))
    else $error("reserved status bit read as one");

  xover_force_a: assert property (
    (rd_status && force_xover_q && !wr_ctrl) |=> rdata[XOVER_BIT])
    else $error("forced crossover not reported");

  xover_track_a: assert property (
    (rd_status && auto_xover_q && !force_xover_q)
      |=> (rdata[XOVER_BIT] == $past(src.algo_swapped)))
    else $error("crossover bit does not track the algorithm");

  rx_err_set_a: assert property (
    src.rx_error |=> rx_err_q ##1 (rx_err_q || $past(rd_rx_err)))
    else $error("receive error not latched");

  rx_err_clear_a: assert property (
    (rx_err_q && !src.rx_error) |=> (rx_err_q == !$past(rd_rx_err)))
    else $error("receive error latch cleared by wrong access");

  pol_keep_a: assert property (
    (polarity_q && rd_status && !rd_ten_base) |=> polarity_q [*1]
      ##0 (rdata[POLARITY_BIT] == 1'b1))
    else $error("polarity bit lost on status read");

  pol_mirror_a: assert property (
    (rd_ten_base && polarity_q) |=> (rdata[TB_POLARITY_BIT] && !polarity_q
      || $past(src.polarity_inverted)))
    else $error("polarity mirror or clear wrong");

  fc_clear_a: assert property (
    (rd_false_car && !src.false_carrier) |=> !false_car_q)
    else $error("false carrier latch not cleared");

  fc_set_a: assert property (
    (src.false_carrier && !rd_false_car) |=> false_car_q [*2] or (false_car_q ##1 1'b1))
    else $error("false carrier not latched");

  sig_hold_low_a: assert property (
    sig_drop_s |=> !sig_det_q)
    else $error("signal detect did not latch low");

  lock_refresh_a: assert property (
    rd_status |=> (lock_q == $past(src.descr_lock)))
    else $error("lock bit not refreshed by status read");

  sig_report_a: assert property (
    status_read_s |=> (rdata[SIG_DET_BIT] == $past(sig_det_q)))
    else $error("signal detect bit misreported");

  irq_level_a: assert property (
    (irq_stat_q[IRQ_RX_ERR] && irq_mask_q[IRQ_RX_ERR]) |-> irq)
    else $error("unmasked status bit without interrupt");

  sequence lock_drop_s;
    src.descr_lock ##1 (!src.descr_lock && !rd_status);
  endsequence

  lock_hold_low_a: assert property (
    lock_drop_s |=> !lock_q)
    else $error("descrambler lock did not latch low");

  sig_refresh_a: assert property (
    status_read_s |=> (sig_det_q == $past(src.signal_detect)))
    else $error("signal detect bit not refreshed by status read");

  lock_report_a: assert property (
    status_read_s |=> (rdata[LOCK_BIT] == $past(lock_q)))
    else $error("lock bit misreported");

  rx_err_report_a: assert property (
    status_read_s |=> (rdata[RX_ERR_BIT] == $past(rx_err_q)))
    else $error("receive error bit misreported");

  fc_report_a: assert property (
    status_read_s |=> (rdata[FALSE_CAR_BIT] == $past(false_car_q)))
    else $error("false carrier bit misreported");

  pol_report_a: assert property (
    status_read_s |=> (rdata[POLARITY_BIT] == $past(polarity_q)))
    else $error("polarity bit misreported");

  pol_set_a: assert property (
    src.polarity_inverted |=> polarity_q)
    else $error("inverted polarity not latched");

  xover_normal_a: assert property (
    (rd_status && !auto_xover_q && !force_xover_q) |=> !rdata[XOVER_BIT])
    else $error("crossover bit set with pairs normal");

  xover_ctrl_a: assert property (
    wr_ctrl |=> (auto_xover_q == $past(req.wdata[AUTO_XOVER_BIT]))
      && (force_xover_q == $past(req.wdata[FORCE_XOVER_BIT])))
    else $error("crossover settings not taken from write");

  rdata_idle_a: assert property (
    !req.rd |=> (rdata == DATA_ZERO))
    else $error("read data present without a read");

  irq_set_a: assert property (
    irq_event[IRQ_RX_ERR] |=> irq_stat_q[IRQ_RX_ERR])
    else $error("interrupt status bit not set by event");

  irq_clear_a: assert property (
    (wr_irq_stat && req.wdata[IRQ_RX_ERR] && !irq_event[IRQ_RX_ERR])
      |=> !irq_stat_q[IRQ_RX_ERR])
    else $error("interrupt status bit not cleared by write");

  irq_masked_a: assert property (
    (irq_mask_q == '0) |-> !irq)
    else $error("interrupt raised with all sources masked");

endmodule

//--- verification/tb_phy_status_upper_bits.sv
module tb_phy_status_upper_bits;
  timeunit 1ns;
  timeprecision 100ps;
  import phy_status_pkg::*;

  logic              clock      = 1'b0;
  logic              nrst       = 1'b0;
  mgmt_req_t         req        = '0;
  phy_sources_t      src        = '0;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic [DATA_W-1:0] got;
  int                mismatches = 0;
  int                checked    = 0;

  always #12.5 clock = ~clock;

  phy_status_upper_bits phy_status_upper_bits_i (
    .clock (clock),
    .nrst  (nrst),
    .req   (req),
    .rdata (rdata),
    .src   (src),
    .irq   (irq)
  );

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cmp1(input string name, input logic exp, input logic seen);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge clock);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: DATA_ZERO};
    @(posedge clock);
    req <= '0;
    #1 got = rdata;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
    #1;
  endtask

  // one-cycle excursion of a source bit to level v
  task automatic blip(input int b, input logic v);
    @(posedge clock);
    src[b] <= v;
    @(posedge clock);
    src[b] <= ~v;
  endtask

  // hold a source bit at level v from the next edge on
  task automatic put(input int b, input logic v);
    @(posedge clock);
    src[b] <= v;
  endtask

  function automatic logic [15:0] stat(input logic xo, rxe, pol, fc, sd, lk);
    return {1'b0, xo, rxe, pol, fc, sd, lk, 9'h000};
  endfunction

  task automatic t_reset();
    rd(STATUS_ADDR);     cmp16("status", 16'h0000, got);
    rd(XOVER_CTRL_ADDR); cmp16("xover_ctrl", 16'h0002, got);
    rd(IRQ_MASK_ADDR);   cmp16("irq_mask", 16'h0000, got);
    rd(5'h05);           cmp16("unmapped", 16'h0000, got);
    cmp1("irq", 1'b0, irq);
  endtask

  task automatic t_reserved();
    wr(STATUS_ADDR, 16'hFFFF);
    rd(STATUS_ADDR); cmp16("status", 16'h0000, got);
  endtask

  task automatic t_xover();
    blip(0, 1'b1);
    put(0, 1'b1);
    rd(STATUS_ADDR); cmp16("status", stat(1, 0, 0, 0, 0, 0), got);
    put(0, 1'b0);
    rd(STATUS_ADDR); cmp16("status", stat(0, 0, 0, 0, 0, 0), got);
    wr(XOVER_CTRL_ADDR, 16'h0001);
    rd(STATUS_ADDR); cmp16("status", stat(1, 0, 0, 0, 0, 0), got);
    put(0, 1'b1);
    wr(XOVER_CTRL_ADDR, 16'h0000);
    rd(STATUS_ADDR); cmp16("status", stat(0, 0, 0, 0, 0, 0), got);
    put(0, 1'b0);
    wr(XOVER_CTRL_ADDR, 16'h0002);
  endtask

  task automatic t_rx_err();
    blip(5, 1'b1);
    rd(STATUS_ADDR);  cmp16("status", stat(0, 1, 0, 0, 0, 0), got);
    rd(STATUS_ADDR);  cmp16("status", stat(0, 1, 0, 0, 0, 0), got);
    rd(FALSE_CAR_ADDR);
    rd(STATUS_ADDR);  cmp16("status", stat(0, 1, 0, 0, 0, 0), got);
    rd(RX_ERR_ADDR);  cmp16("rx_err_cnt", 16'h0000, got);
    rd(STATUS_ADDR);  cmp16("status", stat(0, 0, 0, 0, 0, 0), got);
  endtask

  task automatic t_false_car();
    blip(4, 1'b1);
    rd(STATUS_ADDR);    cmp16("status", stat(0, 0, 0, 1, 0, 0), got);
    rd(RX_ERR_ADDR);
    rd(STATUS_ADDR);    cmp16("status", stat(0, 0, 0, 1, 0, 0), got);
    rd(FALSE_CAR_ADDR); cmp16("false_car_cnt", 16'h0000, got);
    rd(STATUS_ADDR);    cmp16("status", stat(0, 0, 0, 0, 0, 0), got);
  endtask

  task automatic t_polarity();
    blip(3, 1'b1);
    rd(STATUS_ADDR);    cmp16("status", stat(0, 0, 1, 0, 0, 0), got);
    rd(STATUS_ADDR);    cmp16("status", stat(0, 0, 1, 0, 0, 0), got);
    rd(TEN_BASE_ADDR);  cmp16("ten_base", 16'h0010, got);
    rd(STATUS_ADDR);    cmp16("status", stat(0, 0, 0, 0, 0, 0), got);
  endtask

  task automatic t_latch_low();
    put(2, 1'b1);
    put(1, 1'b1);
    rd(STATUS_ADDR);
    rd(STATUS_ADDR); cmp16("status", stat(0, 0, 0, 0, 1, 1), got);
    blip(2, 1'b0);
    rd(STATUS_ADDR); cmp16("status", stat(0, 0, 0, 0, 0, 1), got);
    rd(STATUS_ADDR); cmp16("status", stat(0, 0, 0, 0, 1, 1), got);
    blip(1, 1'b0);
    rd(STATUS_ADDR); cmp16("status", stat(0, 0, 0, 0, 1, 0), got);
    rd(STATUS_ADDR); cmp16("status", stat(0, 0, 0, 0, 1, 1), got);
  endtask

  task automatic t_irq();
    wr(IRQ_STAT_ADDR, 16'h003F);
    wr(IRQ_MASK_ADDR, 16'h0001);
    cmp1("irq", 1'b0, irq);
    blip(5, 1'b1);
    repeat (2) @(posedge clock);
    #1 cmp1("irq", 1'b1, irq);
    rd(IRQ_STAT_ADDR); cmp16("irq_stat", 16'h0001, got);
    wr(IRQ_STAT_ADDR, 16'h0001);
    cmp1("irq", 1'b0, irq);
    wr(IRQ_MASK_ADDR, 16'h0000);
    blip(4, 1'b1);
    repeat (2) @(posedge clock);
    #1 cmp1("irq", 1'b0, irq);
    rd(IRQ_STAT_ADDR); cmp16("irq_stat", 16'h0002, got);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    $display("BAD watchdog expected finish seen hang");
    test_done();
  end

  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_reserved();
    t_xover();
    t_rx_err();
    t_false_car();
    t_polarity();
    t_latch_low();
    t_irq();
    test_done();
  end
endmodule
